// file: bench/cml_exec_tb_top.sv
// Purpose: random self-checking run of the execution unit
// Assumes: one result edge after each take, dummy cycle after exits/skips
// Notes: memory write data and address are checked only on write pulses
module cml_exec_tb_top
	import cml_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk, reset, op_valid;
	logic [4:0] op_code;
	logic [7:0] op_imm, mem_rdata, acc_value, mem_wr_data;
	logic [CML_ADDR_W-1:0] op_addr, mem_wr_addr;
	logic [CML_PC_W-1:0] stack_pc, prog_counter;
	logic op_ready, op_done, flag_zero, flag_carry, nibble_carry_flag;
	logic arith_sign_error_flag, mem_wr_en, stack_pop;
	logic global_irq_enable, skip_pulse;
	int mismatches, comparisons, i;
	// reference state
	logic [7:0] ram [0:1023];
	logic [CML_PC_W-1:0] stk [0:15];
	logic [3:0] sp;
	logic [7:0] e_acc, e_wd;
	logic [CML_ADDR_W-1:0] e_wa;
	logic [CML_PC_W-1:0] e_pc;
	logic e_z, e_c, e_ac, e_ov, e_irq, e_rdy, e_done, e_wr, e_pop, e_skip;

	cml_exec uut (.core_clk(core_clk), .reset(reset), .op_valid(op_valid),
		.op_code(op_code), .op_imm(op_imm), .op_addr(op_addr),
		.mem_rdata(mem_rdata), .stack_pc(stack_pc), .op_ready(op_ready),
		.op_done(op_done), .acc_value(acc_value), .flag_zero(flag_zero),
		.flag_carry(flag_carry), .nibble_carry_flag(nibble_carry_flag),
		.arith_sign_error_flag(arith_sign_error_flag),
		.mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
		.mem_wr_addr(mem_wr_addr), .prog_counter(prog_counter),
		.stack_pop(stack_pop), .global_irq_enable(global_irq_enable),
		.skip_pulse(skip_pulse));

	cml_mem_model mem (.core_clk(core_clk), .rd_addr(op_addr),
		.rd_data(mem_rdata), .wr_en(mem_wr_en), .wr_data(mem_wr_data),
		.wr_addr(mem_wr_addr), .pop(stack_pop), .stack_top(stack_pc));

	// free running core clock
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic cmp1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp14(input logic [13:0] got, input logic [13:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic set_reset();
		{e_acc, e_wd, e_wa, e_pc} = '0;
		{e_z, e_c, e_ac, e_ov, e_irq, e_done, e_wr, e_pop, e_skip} = '0;
		e_rdy = 1'b1;
	endtask

	// every output against the reference after the result edge, write data and address only on writes
	task automatic check_all();
		cmp1(op_ready, e_rdy);
		cmp1(op_done, e_done);
		cmp8(acc_value, e_acc);
		cmp1(flag_zero, e_z);
		cmp1(flag_carry, e_c);
		cmp1(nibble_carry_flag, e_ac);
		cmp1(arith_sign_error_flag, e_ov);
		cmp14(prog_counter, e_pc);
		cmp1(stack_pop, e_pop);
		cmp1(global_irq_enable, e_irq);
		cmp1(mem_wr_en, e_wr);
		cmp1(skip_pulse, e_skip);
		if (e_wr) begin
			cmp8(mem_wr_data, e_wd);
			cmp14(14'(mem_wr_addr), 14'(e_wa));
		end
	endtask

	task automatic wr(input logic [7:0] v);
		e_wr = 1'b1;
		e_wd = v;
		e_wa = op_addr;
		ram[op_addr] = v;
	endtask

	// reference execution of one taken operation
	task automatic model_op();
		logic [7:0] m, nm;
		logic [8:0] s;
		m = ram[op_addr];
		nm = ~m;
		s = 9'(e_acc) + 9'(nm) + 9'(e_c);
		e_done = 1'b1;
		e_pc = e_pc + 14'h1;
		case (op_code)
			CML_COPY_OP_MEM_TO_W: e_acc = m;
			CML_COPY_OP_IMM_TO_W: e_acc = op_imm;
			CML_COPY_OP_W_TO_MEM: wr(e_acc);
			CML_INCLUSIVE_MEM_OP, CML_INCLUSIVE_IMM_OP: begin
				e_acc = e_acc | (op_code == CML_INCLUSIVE_MEM_OP ? m : op_imm);
				e_z = (e_acc == 8'h00);
			end
			CML_INCLUSIVE_TO_RAM_OP: begin
				wr(e_acc | m);
				e_z = (e_wd == 8'h00);
			end
			CML_SUBROUTINE_EXIT_OP, CML_EXIT_WITH_CONST_OP,
			CML_INTERRUPT_EXIT_OP: begin
				e_pc = stk[sp];
				sp = sp - 4'h1;
				e_pop = 1'b1;
				e_rdy = 1'b0;
				if (op_code == CML_EXIT_WITH_CONST_OP)
					e_acc = op_imm;
				if (op_code == CML_INTERRUPT_EXIT_OP)
					e_irq = 1'b1;
			end
			CML_ROTATE_LEFT_OP: wr({m[6:0], m[7]});
			CML_ROTATE_LEFT_TO_WORKING: e_acc = {m[6:0], m[7]};
			CML_ROTATE_LEFT_THRU_CY: begin
				wr({m[6:0], e_c});
				e_c = m[7];
			end
			CML_ROTATE_LEFT_THRU_CY_TO_WORKING: begin
				e_acc = {m[6:0], e_c};
				e_c = m[7];
			end
			CML_ROTATE_RIGHT_OP: wr({m[0], m[7:1]});
			CML_ROTATE_RIGHT_TO_WORKING: e_acc = {m[0], m[7:1]};
			CML_ROTATE_RIGHT_THRU_CY: begin
				wr({e_c, m[7:1]});
				e_c = m[0];
			end
			CML_ROTATE_RIGHT_THRU_CY_TO_WORKING: begin
				e_acc = {e_c, m[7:1]};
				e_c = m[0];
			end
			CML_SUBTRACT_WITH_BORROW_OP, CML_SUBTRACT_WITH_BORROW_TO_RAM: begin
				e_ac = (5'(e_acc[3:0]) + 5'(nm[3:0]) + 5'(e_c)) > 5'h0F;
				e_ov = (e_acc[7] == nm[7]) && (s[7] != e_acc[7]);
				e_c = s[8];
				e_z = (s[7:0] == 8'h00);
				if (op_code == CML_SUBTRACT_WITH_BORROW_OP)
					e_acc = s[7:0];
				else
					wr(s[7:0]);
			end
			CML_DECREMENT_SKIP_IF_ZERO, CML_DECREMENT_SKIP_IF_ZERO_TO_WORKING: begin
				if (op_code == CML_DECREMENT_SKIP_IF_ZERO)
					wr(m - 8'h01);
				else
					e_acc = m - 8'h01;
				if (m == 8'h01) begin
					e_skip = 1'b1;
					e_rdy = 1'b0;
					e_pc = e_pc + 14'h1;
				end
			end
			default: ;
		endcase
	endtask

	// random request, refused while the dummy cycle runs
	task automatic drive_op();
		op_valid = ($urandom % 4) != 0;
		op_code = 5'($urandom % 24);
		op_imm = 8'($urandom);
		op_addr = CML_ADDR_W'($urandom % 8);
		{e_done, e_wr, e_pop, e_skip} = '0;
		if (!e_rdy)
			e_rdy = 1'b1;
		else if (op_valid)
			model_op();
	endtask

	// preload, reset, random run with a second reset midway
	initial begin
		mismatches = 0;
		comparisons = 0;
		void'($urandom(92));
		{reset, op_valid, op_code, op_imm, op_addr} = {1'b1, 24'h0};
		for (i = 0; i < 1024; i++) begin
			ram[i] = 8'($urandom % 4);
			mem.ram[i] = ram[i];
		end
		for (i = 0; i < 16; i++) begin
			stk[i] = CML_PC_W'($urandom);
			mem.stk[i] = stk[i];
		end
		sp = 4'h0;
		mem.sp = 4'h0;
		set_reset();
		repeat (16) @(negedge core_clk);
		reset = 1'b0;
		for (i = 0; i < 3000; i++) begin
			@(negedge core_clk);
			check_all();
			reset = (i == 1500);
			if (reset) begin
				op_valid = 1'b0;
				set_reset();
			end else
				drive_op();
		end
		test_done();
	end
endmodule

// file: bench/cml_mem_model.sv
// Purpose: data memory and return stack seen by the execution unit
// Assumes: bench preloads ram, stk and sp before reset ends
// Notes: a write in flight is forwarded to the read port
module cml_mem_model
	import cml_pkg::*;
(
	input wire logic core_clk,
	input wire logic [CML_ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [CML_ADDR_W-1:0] wr_addr,
	input wire logic pop,
	output logic [CML_PC_W-1:0] stack_top
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] ram [0:1023];
	logic [CML_PC_W-1:0] stk [0:15];
	logic [3:0] sp;

	// byte store and stack pointer step on the clock
	always @(posedge core_clk) begin
		if (wr_en)
			ram[wr_addr] <= wr_data;
		if (pop)
			sp <= sp - 4'h1;
	end

	// read sees a write of the same cycle, avoiding a stale byte
	assign rd_data = (wr_en && wr_addr == rd_addr) ? wr_data : ram[rd_addr];
	assign stack_top = stk[sp];
endmodule

// file: common/cml_pkg.sv
// Purpose: constants and types for the move, logic, rotate, return unit
// Assumes: one core clock, synchronous active-high reset
// Notes: opcode codes are this unit's own select encoding
package cml_pkg;

	// data memory address, program counter and data widths
	localparam int CML_ADDR_W = 10;
	localparam int CML_PC_W = 14;
	localparam int CML_DATA_W = 8;

	// bit positions used by rotates and the nibble carry
	localparam int CML_MSB = 7;
	localparam int CML_NIB_MSB = 3;

	// reset values and the interrupt enable set value
	localparam logic [7:0] CML_ACC_RST = 8'h00;
	localparam logic CML_FLAG_RST = 1'b0;
	localparam logic CML_IRQ_EN_RST = 1'b0;
	localparam logic CML_IRQ_EN_SET = 1'b1;

	// program counter steps
	localparam int CML_PC_STEP = 1;
	localparam int CML_PC_SKIP_STEP = 2;

	// operation select codes
	typedef enum logic [4:0] {
		CML_COPY_OP_MEM_TO_W = 5'h00,
		CML_COPY_OP_IMM_TO_W = 5'h01,
		CML_COPY_OP_W_TO_MEM = 5'h02,
		CML_IDLE_OP = 5'h03,
		CML_INCLUSIVE_MEM_OP = 5'h04,
		CML_INCLUSIVE_IMM_OP = 5'h05,
		CML_INCLUSIVE_TO_RAM_OP = 5'h06,
		CML_SUBROUTINE_EXIT_OP = 5'h07,
		CML_EXIT_WITH_CONST_OP = 5'h08,
		CML_INTERRUPT_EXIT_OP = 5'h09,
		CML_ROTATE_LEFT_OP = 5'h0A,
		CML_ROTATE_LEFT_TO_WORKING = 5'h0B,
		CML_ROTATE_LEFT_THRU_CY = 5'h0C,
		CML_ROTATE_LEFT_THRU_CY_TO_WORKING = 5'h0D,
		CML_ROTATE_RIGHT_OP = 5'h0E,
		CML_ROTATE_RIGHT_TO_WORKING = 5'h0F,
		CML_ROTATE_RIGHT_THRU_CY = 5'h10,
		CML_ROTATE_RIGHT_THRU_CY_TO_WORKING = 5'h11,
		CML_SUBTRACT_WITH_BORROW_OP = 5'h12,
		CML_SUBTRACT_WITH_BORROW_TO_RAM = 5'h13,
		CML_DECREMENT_SKIP_IF_ZERO = 5'h14,
		CML_DECREMENT_SKIP_IF_ZERO_TO_WORKING = 5'h15
	} cml_op_e;

	// sequencer states
	typedef enum logic [1:0] {
		CML_ST_READY = 2'b01,
		CML_ST_DUMMY = 2'b10
	} cml_state_e;

endpackage

// file: logic/cml_exec.sv
// Purpose: execution of moves, OR, returns, rotates, borrow subtract, skips
// Assumes: mem_rdata is the byte at op_addr in the same cycle
// Notes: outputs update one edge after an operation is taken
// Operation
// - memory to accumulator copy, flags untouched
// - immediate 8-bit constant loads accumulator, flags untouched
// - accumulator written to addressed memory byte, flags untouched
// - idle op only steps program counter by one
// - OR of accumulator with memory or immediate into accumulator, zero only
// - OR result written back to memory byte, zero flag only
// - subroutine exit pops program counter, two cycles, no flags
// - exit with constant pops counter and loads immediate into accumulator
// - interrupt exit pops counter and sets global interrupt enable
// - rotate memory byte left in place, bit 7 into bit 0
// - left rotated memory byte to accumulator, memory and flags kept
// - rotate memory left through carry in place, only carry changes
// - nine-bit left rotation into accumulator and carry, memory kept
// - rotate memory byte right in place, bit 0 into bit 7
// - right rotated memory byte to accumulator, memory and flags kept
// - rotate memory right through carry in place, only carry changes
// - nine-bit right rotation into accumulator and carry, memory kept
// - accumulator plus inverted byte plus carry into accumulator, four flags
// - same borrow subtract written to memory, four flags updated
// - decrement memory in place, skip next op if zero, two cycles on skip
// - decrement into accumulator, memory kept, skip if zero, no flags
module cml_exec
	import cml_pkg::*;
#(
	parameter int ADDR_W = CML_ADDR_W,
	parameter int PC_W = CML_PC_W
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic op_valid,
	input wire logic [4:0] op_code,
	input wire logic [7:0] op_imm,
	input wire logic [ADDR_W-1:0] op_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic [PC_W-1:0] stack_pc,
	output logic op_ready,
	output logic op_done,
	output logic [7:0] acc_value,
	output logic flag_zero,
	output logic flag_carry,
	output logic nibble_carry_flag,
	output logic arith_sign_error_flag,
	output logic mem_wr_en,
	output logic [7:0] mem_wr_data,
	output logic [ADDR_W-1:0] mem_wr_addr,
	output logic [PC_W-1:0] prog_counter,
	output logic stack_pop,
	output logic global_irq_enable,
	output logic skip_pulse
);

	// rotate by one; returns {carry out, byte}
	function automatic logic [8:0] cml_rotate(input logic [7:0] v,
		input logic cy, input logic left, input logic thru);
		logic fill;
		fill = 1'b0;
		if (left) begin
			fill = thru ? cy : v[CML_MSB];
			cml_rotate = {v[CML_MSB], v[CML_MSB-1:0], fill};
		end else begin
			fill = thru ? cy : v[0];
			cml_rotate = {v[0], fill, v[CML_MSB:1]};
		end
	endfunction

	cml_state_e state_reg, state_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	logic [7:0] acc_reg, acc_next;
	logic zero_reg, zero_next;
	logic carry_reg, carry_next;
	logic nib_reg, nib_next;
	logic sign_err_reg, sign_err_next;
	logic we_reg, we_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic pop_reg, pop_next;
	logic irq_en_reg, irq_en_next;
	logic skip_reg, skip_next;

	logic [8:0] rot_l, rot_lc, rot_r, rot_rc;
	logic [8:0] borrow_sum;
	logic [4:0] borrow_nib;
	logic borrow_ovf;
	logic [7:0] or_mem, or_imm, dec_val;
	logic [PC_W-1:0] pc_inc, pc_skip;

	// operand datapaths
	assign rot_l = cml_rotate(mem_rdata, carry_reg, 1'b1, 1'b0);
	assign rot_lc = cml_rotate(mem_rdata, carry_reg, 1'b1, 1'b1);
	assign rot_r = cml_rotate(mem_rdata, carry_reg, 1'b0, 1'b0);
	assign rot_rc = cml_rotate(mem_rdata, carry_reg, 1'b0, 1'b1);
	assign borrow_sum = {1'b0, acc_reg} + {1'b0, ~mem_rdata}
		+ {8'h00, carry_reg};
	assign borrow_nib = {1'b0, acc_reg[CML_NIB_MSB:0]}
		+ {1'b0, ~mem_rdata[CML_NIB_MSB:0]} + {4'h0, carry_reg};
	assign borrow_ovf = (acc_reg[CML_MSB] == ~mem_rdata[CML_MSB])
		&& (borrow_sum[CML_MSB] != acc_reg[CML_MSB]);
	assign or_mem = acc_reg | mem_rdata;
	assign or_imm = acc_reg | op_imm;
	assign dec_val = mem_rdata - 8'h01;
	assign pc_inc = pc_reg + PC_W'(CML_PC_STEP);
	assign pc_skip = pc_reg + PC_W'(CML_PC_SKIP_STEP);

	// next-state and datapath decode
	always_comb begin
		state_next = state_reg;
		done_next = 1'b0;
		acc_next = acc_reg;
		zero_next = zero_reg;
		carry_next = carry_reg;
		nib_next = nib_reg;
		sign_err_next = sign_err_reg;
		we_next = 1'b0;
		wdata_next = wdata_reg;
		waddr_next = waddr_reg;
		pc_next = pc_reg;
		pop_next = 1'b0;
		irq_en_next = irq_en_reg;
		skip_next = 1'b0;
		case (state_reg)
			CML_ST_READY: begin
				if (op_valid) begin
					done_next = 1'b1;
					pc_next = pc_inc;
					waddr_next = op_addr;
					case (op_code)
						CML_COPY_OP_MEM_TO_W: begin
							acc_next = mem_rdata;
						end
						CML_COPY_OP_IMM_TO_W: begin
							acc_next = op_imm;
						end
						CML_COPY_OP_W_TO_MEM: begin
							we_next = 1'b1;
							wdata_next = acc_reg;
						end
						CML_INCLUSIVE_MEM_OP: begin
							acc_next = or_mem;
							zero_next = (or_mem == 8'h00);
						end
						CML_INCLUSIVE_IMM_OP: begin
							acc_next = or_imm;
							zero_next = (or_imm == 8'h00);
						end
						CML_INCLUSIVE_TO_RAM_OP: begin
							we_next = 1'b1;
							wdata_next = or_mem;
							zero_next = (or_mem == 8'h00);
						end
						CML_SUBROUTINE_EXIT_OP: begin
							pc_next = stack_pc;
							pop_next = 1'b1;
							state_next = CML_ST_DUMMY;
						end
						CML_EXIT_WITH_CONST_OP: begin
							pc_next = stack_pc;
							pop_next = 1'b1;
							acc_next = op_imm;
							state_next = CML_ST_DUMMY;
						end
						CML_INTERRUPT_EXIT_OP: begin
							pc_next = stack_pc;
							pop_next = 1'b1;
							irq_en_next = CML_IRQ_EN_SET;
							state_next = CML_ST_DUMMY;
						end
						CML_ROTATE_LEFT_OP: begin
							we_next = 1'b1;
							wdata_next = rot_l[7:0];
						end
						CML_ROTATE_LEFT_TO_WORKING: begin
							acc_next = rot_l[7:0];
						end
						CML_ROTATE_LEFT_THRU_CY: begin
							we_next = 1'b1;
							wdata_next = rot_lc[7:0];
							carry_next = rot_lc[8];
						end
						CML_ROTATE_LEFT_THRU_CY_TO_WORKING: begin
							acc_next = rot_lc[7:0];
							carry_next = rot_lc[8];
						end
						CML_ROTATE_RIGHT_OP: begin
							we_next = 1'b1;
							wdata_next = rot_r[7:0];
						end
						CML_ROTATE_RIGHT_TO_WORKING: begin
							acc_next = rot_r[7:0];
						end
						CML_ROTATE_RIGHT_THRU_CY: begin
							we_next = 1'b1;
							wdata_next = rot_rc[7:0];
							carry_next = rot_rc[8];
						end
						CML_ROTATE_RIGHT_THRU_CY_TO_WORKING: begin
							acc_next = rot_rc[7:0];
							carry_next = rot_rc[8];
						end
						CML_SUBTRACT_WITH_BORROW_OP,
						CML_SUBTRACT_WITH_BORROW_TO_RAM: begin
							if (op_code == CML_SUBTRACT_WITH_BORROW_OP) begin
								acc_next = borrow_sum[7:0];
							end else begin
								we_next = 1'b1;
								wdata_next = borrow_sum[7:0];
							end
							zero_next = (borrow_sum[7:0] == 8'h00);
							carry_next = borrow_sum[8];
							nib_next = borrow_nib[4];
							sign_err_next = borrow_ovf;
						end
						CML_DECREMENT_SKIP_IF_ZERO,
						CML_DECREMENT_SKIP_IF_ZERO_TO_WORKING: begin
							if (op_code == CML_DECREMENT_SKIP_IF_ZERO) begin
								we_next = 1'b1;
								wdata_next = dec_val;
							end else begin
								acc_next = dec_val;
							end
							if (dec_val == 8'h00) begin
								pc_next = pc_skip;
								skip_next = 1'b1;
								state_next = CML_ST_DUMMY;
							end
						end
						default: begin
							// idle op and unused codes only step the counter
							acc_next = acc_reg;
						end
					endcase
				end
			end
			CML_ST_DUMMY: begin
				state_next = CML_ST_READY;
			end
			default: begin
				state_next = CML_ST_READY;
			end
		endcase
		ready_next = (state_next == CML_ST_READY);
	end

	// register all state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= CML_ST_READY;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			acc_reg <= CML_ACC_RST;
			zero_reg <= CML_FLAG_RST;
			carry_reg <= CML_FLAG_RST;
			nib_reg <= CML_FLAG_RST;
			sign_err_reg <= CML_FLAG_RST;
			we_reg <= 1'b0;
			wdata_reg <= 8'h00;
			waddr_reg <= '0;
			pc_reg <= '0;
			pop_reg <= 1'b0;
			irq_en_reg <= CML_IRQ_EN_RST;
			skip_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			acc_reg <= acc_next;
			zero_reg <= zero_next;
			carry_reg <= carry_next;
			nib_reg <= nib_next;
			sign_err_reg <= sign_err_next;
			we_reg <= we_next;
			wdata_reg <= wdata_next;
			waddr_reg <= waddr_next;
			pc_reg <= pc_next;
			pop_reg <= pop_next;
			irq_en_reg <= irq_en_next;
			skip_reg <= skip_next;
		end
	end

	// outputs straight from flops
	assign op_ready = ready_reg;
	assign op_done = done_reg;
	assign acc_value = acc_reg;
	assign flag_zero = zero_reg;
	assign flag_carry = carry_reg;
	assign nibble_carry_flag = nib_reg;
	assign arith_sign_error_flag = sign_err_reg;
	assign mem_wr_en = we_reg;
	assign mem_wr_data = wdata_reg;
	assign mem_wr_addr = waddr_reg;
	assign prog_counter = pc_reg;
	assign stack_pop = pop_reg;
	assign global_irq_enable = irq_en_reg;
	assign skip_pulse = skip_reg;

	// checks on the executed results
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_take(logic [4:0] code);
		op_valid && state_reg == CML_ST_READY && op_code == code;
	endsequence

	sequence s_dummy_then_ready;
		!ready_reg ##1 ready_reg;
	endsequence

	a_copy_mem_acc: assert property (s_take(CML_COPY_OP_MEM_TO_W) |=>
		acc_reg == $past(mem_rdata) && !we_reg
		&& $stable({zero_reg, carry_reg, nib_reg, sign_err_reg}))
		else $error("memory copy to accumulator wrong");
	a_copy_imm_acc: assert property (s_take(CML_COPY_OP_IMM_TO_W) |=>
		acc_reg == $past(op_imm) && $stable(zero_reg))
		else $error("immediate load wrong");
	a_acc_to_mem: assert property (s_take(CML_COPY_OP_W_TO_MEM) |=>
		we_reg && wdata_reg == $past(acc_reg)
		&& waddr_reg == $past(op_addr))
		else $error("accumulator store wrong");
	a_idle_pc_step: assert property (s_take(CML_IDLE_OP) |=>
		pc_reg - $past(pc_reg) == PC_W'(1) && !we_reg && $stable(acc_reg))
		else $error("idle op changed state");
	a_or_zero_flag: assert property (s_take(CML_INCLUSIVE_IMM_OP) |=>
		acc_reg == ($past(acc_reg) | $past(op_imm))
		&& zero_reg == (acc_reg == 8'h00) && $stable(carry_reg))
		else $error("or immediate wrong");
	a_or_to_mem: assert property (s_take(CML_INCLUSIVE_TO_RAM_OP) |=>
		we_reg && wdata_reg == ($past(acc_reg) | $past(mem_rdata))
		&& $stable(acc_reg))
		else $error("or to memory wrong");
	a_sub_exit_two: assert property (s_take(CML_SUBROUTINE_EXIT_OP) |=>
		pop_reg && pc_reg == $past(stack_pc) ##0 s_dummy_then_ready)
		else $error("subroutine exit timing wrong");
	a_irq_exit_set: assert property (s_take(CML_INTERRUPT_EXIT_OP) |=>
		irq_en_reg && pop_reg && $stable(zero_reg))
		else $error("interrupt exit did not enable");
	a_rotate_left_cy: assert property (s_take(CML_ROTATE_LEFT_THRU_CY) |=>
		wdata_reg == {$past(mem_rdata[6:0]), $past(carry_reg)}
		&& carry_reg == $past(mem_rdata[7]))
		else $error("left rotate through carry wrong");
	a_rotate_right: assert property (s_take(CML_ROTATE_RIGHT_TO_WORKING) |=>
		acc_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
		&& !we_reg && $stable(carry_reg))
		else $error("right rotate to accumulator wrong");
	a_borrow_carry: assert property (s_take(CML_SUBTRACT_WITH_BORROW_OP) |=>
		{carry_reg, acc_reg} == {1'b0, $past(acc_reg)}
		+ {1'b0, ~$past(mem_rdata)} + {8'h00, $past(carry_reg)})
		else $error("borrow subtract wrong");
	a_skip_on_zero: assert property (s_take(CML_DECREMENT_SKIP_IF_ZERO)
		##0 mem_rdata == 8'h01 |=> skip_pulse && we_reg
		&& wdata_reg == 8'h00 ##0 s_dummy_then_ready)
		else $error("decrement skip wrong");

endmodule
